// ==== timer_event_counter_16bit.v ====
// 16-bit timer/event counter with two capture/compare registers.
//
// Notes on behaviour
// RULE1 - Counter increments on each count enable while running.
// RULE2 - Counter reads live when running, else zero.
// RULE3 - Counter clears at reset and on stop.
// RULE4 - Run field: stop, free, edge clear, match clear.
// RULE5 - Edge clear mode restarts counter on edge_in_a.
// RULE6 - Match clear mode restarts counter on A match.
// RULE7 - One-shot restarts on software trigger or edge; the code ignores the edge in match clear mode.
// RULE8 - Counter reads never capture into register B.
// RULE9 - Compare A matches continuously, raises match_irq_a.
// RULE10 - Compare B matches continuously, raises match_irq_b.
// RULE11 - No capture into a register in compare mode.
// RULE12 - Edge select: 00 fall, 01 rise, 11 both.
// RULE13 - Source one captures A on reverse edge.
// RULE14 - Reverse capture silent; edge_in_b gives irq A.
// RULE15 - Source zero captures A on edge_in_b, irq.
// RULE16 - Capture B on edge_in_a, raise irq B.
// RULE17 - Compare zero first matches on zero-to-one step.
// RULE18 - Software keeps compare values within range.
// RULE19 - Captured value held; rewrite after mode change.
// RULE20 - Stop before switching capture to compare.
// RULE21 - Write A only when stopped, 16-bit access.
// RULE22 - Mode control rewritten only to stop/clear flag.
// RULE23 - Overflow flag sets on wrap to zero.
// RULE24 - Capture pulses last two extra count periods.
// RULE25 - Both edge inputs synchronised before detection.
`timescale 1ns/10ps
`include "tec16_map.vh"
module timer_event_counter_16bit #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_arst_n,
  // Selected count clock as a one-cycle enable
  input wire i_count_en,
  // Memory bus, one byte per access
  input wire [15:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // External pins
  input wire i_edge_in_a,
  input wire i_edge_in_b,
  output reg o_timer_out,
  // Interrupt requests, one-cycle pulses
  output reg o_match_irq_a,
  output reg o_match_irq_b
);
  reg [WIDTH-1:0] count_value;
  reg [WIDTH-1:0] compare_capture_a;
  reg [WIDTH-1:0] compare_capture_b;
  reg [7:0] mode_control;
  reg [7:0] cc_control;
  reg [7:0] output_control;
  reg [7:0] prescale_edge_select;
  reg [7:0] wlatch_a;
  reg [7:0] wlatch_b;
  reg [7:0] rlatch;
  reg tout;
  reg [WIDTH-1:0] next_count;
  reg next_irq_a;
  reg next_irq_b;
  reg next_tout;
  reg ovf_set;
  reg [7:0] next_rdata;
  reg [7:0] next_rlatch;
  wire [1:0] run_mode;
  wire running;
  wire valid_a;
  wire reverse_a;
  wire valid_b;
  wire edge_restart;
  wire match_a;
  wire match_b;
  wire sw_trigger;
  wire oneshot_mode;
  wire wr_mode;
  wire wr_cc_ctl;
  wire wr_prescale;
  wire wr_out_ctl;
  wire wr_a_lo;
  wire wr_a_hi;
  wire wr_b_lo;
  wire wr_b_hi;
  wire capt_a;
  wire capt_b;
  wire irq_from_b;

  function sel_hit;
    input [15:0] addr;
    input [15:0] target;
    input strobe;
    begin
      sel_hit = strobe && (addr == target);
    end
  endfunction

  // ---------------------------------------------------------------
  // Bus write decode
  // ---------------------------------------------------------------
  // Every register is one byte lane; a 16-bit register pairs a latch
  // for its low byte with the write of its high byte.
  assign wr_mode = sel_hit(i_addr, `ADDR_MODE_CONTROL, i_wr);
  assign wr_cc_ctl = sel_hit(i_addr, `ADDR_CC_CONTROL, i_wr);
  assign wr_prescale = sel_hit(i_addr, `ADDR_PRESCALE, i_wr);
  assign wr_out_ctl = sel_hit(i_addr, `ADDR_OUTPUT_CONTROL, i_wr);
  assign wr_a_lo = sel_hit(i_addr, `ADDR_CC_A, i_wr);
  assign wr_a_hi = sel_hit(i_addr, `ADDR_CC_A_HI, i_wr); // RULE21
  assign wr_b_lo = sel_hit(i_addr, `ADDR_CC_B, i_wr);
  assign wr_b_hi = sel_hit(i_addr, `ADDR_CC_B_HI, i_wr);

  // ---------------------------------------------------------------
  // Edge inputs
  // ---------------------------------------------------------------
  edge_sync u_sync_a (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_edge_in_a),
    .i_sel(prescale_edge_select[`PS_EA_HI:`PS_EA_LO]),
    .o_valid(valid_a),
    .o_reverse(reverse_a)
  );
  edge_sync u_sync_b (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_edge_in_b),
    .i_sel(prescale_edge_select[`PS_EB_HI:`PS_EB_LO]),
    .o_valid(valid_b),
    .o_reverse()
  );

  // ---------------------------------------------------------------
  // Counter control
  // ---------------------------------------------------------------
  assign run_mode = mode_control[`MC_RUN_HI:`MC_RUN_LO]; // RULE4
  assign running = (run_mode != `RUN_STOP);
  assign oneshot_mode = output_control[`OC_ONESHOT];
  assign sw_trigger = wr_out_ctl & i_wdata[`OC_TRIG] & oneshot_mode;
  // Compare matches are taken on the count enable that leaves the
  // matching value, so a compare of zero is first seen on the step
  // from zero to one rather than straight after start or clear.
  assign match_a = running && i_count_en && !cc_control[`CC_A_CAPT] &&
    (count_value == compare_capture_a); // RULE9 RULE17
  assign match_b = running && i_count_en && !cc_control[`CC_B_CAPT] &&
    (count_value == compare_capture_b); // RULE10 RULE17
  assign edge_restart = valid_a && (run_mode == `RUN_CLR_EDGE ||
    (oneshot_mode && run_mode != `RUN_CLR_MATCH)); // RULE5 RULE7

  // Captures run only while counting and only in capture mode, so a
  // register set up for compare is never overwritten by a trigger.
  assign capt_a = running && cc_control[`CC_A_CAPT] &&
    (cc_control[`CC_A_SRC] ? reverse_a : valid_b); // RULE11 RULE13
  assign capt_b = running && cc_control[`CC_B_CAPT] &&
    valid_a; // RULE11 RULE16
  assign irq_from_b = running && cc_control[`CC_A_CAPT] &&
    valid_b; // RULE14 RULE15

  always @* begin
    next_count = count_value;
    ovf_set = 1'b0;
    if (!running) begin
      next_count = `RST16; // RULE3
    end else if (edge_restart || sw_trigger) begin
      next_count = `RST16; // RULE5 RULE7
    end else if (run_mode == `RUN_CLR_MATCH && match_a) begin
      next_count = `RST16; // RULE6
    end else if (i_count_en) begin
      next_count = count_value + `COUNT_ONE; // RULE1
      if (count_value == `COUNT_MAX) begin
        ovf_set = 1'b1; // RULE23
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt requests
  // ---------------------------------------------------------------
  // Irq A: compare match, capture from edge_in_b, or the external
  // interrupt form when A captures on the reverse edge of edge_in_a.
  always @* begin
    next_irq_a = match_a;
    next_irq_b = match_b;
    if (irq_from_b) begin
      next_irq_a = 1'b1; // RULE14 RULE15
    end
    if (capt_b) begin
      next_irq_b = 1'b1; // RULE16
    end
  end

  // ---------------------------------------------------------------
  // Timer output
  // ---------------------------------------------------------------
  // The level set and reset bits act once when written; none is stored.
  always @* begin
    next_tout = tout;
    if ((match_a && mode_control[`MC_INV] && output_control[`OC_INV_A]) ^
        (match_b && output_control[`OC_INV_B])) begin
      next_tout = ~tout;
    end
    if (wr_out_ctl) begin
      if (i_wdata[`OC_LVS]) begin
        next_tout = 1'b1;
      end else if (i_wdata[`OC_LVR]) begin
        next_tout = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // A low-byte count read snapshots the high byte so a 16-bit read is
  // coherent; no read ever touches register B.
  always @* begin
    next_rdata = `RST8;
    next_rlatch = rlatch;
    if (i_rd) begin // RULE8
      case (i_addr)
        `ADDR_COUNT: begin
          next_rdata = running ? count_value[7:0] : `RST8; // RULE2
          next_rlatch = running ? count_value[15:8] : `RST8;
        end
        `ADDR_COUNT_HI: next_rdata = running ? rlatch : `RST8; // RULE2
        `ADDR_CC_A: next_rdata = compare_capture_a[7:0];
        `ADDR_CC_A_HI: next_rdata = compare_capture_a[15:8];
        `ADDR_CC_B: next_rdata = compare_capture_b[7:0];
        `ADDR_CC_B_HI: next_rdata = compare_capture_b[15:8];
        `ADDR_MODE_CONTROL: next_rdata = mode_control;
        `ADDR_CC_CONTROL: next_rdata = cc_control;
        `ADDR_PRESCALE: next_rdata = prescale_edge_select;
        `ADDR_OUTPUT_CONTROL: next_rdata = output_control;
        default: next_rdata = `RST8;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_value <= `RST16; // RULE3
      compare_capture_a <= `RST16;
      compare_capture_b <= `RST16;
      mode_control <= `RST8;
      cc_control <= `RST8;
      output_control <= `RST8;
      prescale_edge_select <= `RST8;
      wlatch_a <= `RST8;
      wlatch_b <= `RST8;
      rlatch <= `RST8;
      tout <= 1'b0;
      o_timer_out <= 1'b0;
      o_match_irq_a <= 1'b0;
      o_match_irq_b <= 1'b0;
      o_rdata <= `RST8;
    end else begin
      count_value <= next_count;
      tout <= next_tout;
      o_timer_out <= next_tout & output_control[`OC_ENABLE];
      o_match_irq_a <= next_irq_a;
      o_match_irq_b <= next_irq_b;
      // Overflow set wins over a software clear in the same cycle.
      if (wr_mode) begin // RULE22
        mode_control <= {4'h0, i_wdata[3:1],
          i_wdata[`MC_OVF] | ovf_set};
      end else if (ovf_set) begin
        mode_control[`MC_OVF] <= 1'b1; // RULE23
      end
      if (wr_cc_ctl) begin
        cc_control <= {5'h00, i_wdata[2:0]};
      end
      if (wr_prescale) begin
        prescale_edge_select <= i_wdata;
      end
      if (wr_out_ctl) begin
        output_control <= {3'h0, i_wdata[4], 2'h0, i_wdata[1:0]} |
          {2'h0, i_wdata[5], 5'h00};
      end
      // Capture/compare A: low byte held until the high byte lands.
      if (wr_a_lo) begin
        wlatch_a <= i_wdata;
      end
      if (wr_a_hi) begin // RULE21
        compare_capture_a <= {i_wdata, wlatch_a};
      end else if (capt_a) begin
        compare_capture_a <= count_value; // RULE13 RULE15 RULE19
      end
      if (wr_b_lo) begin
        wlatch_b <= i_wdata;
      end
      if (wr_b_hi) begin
        compare_capture_b <= {i_wdata, wlatch_b};
      end else if (capt_b) begin
        compare_capture_b <= count_value; // RULE16 RULE11
      end
      o_rdata <= next_rdata;
      rlatch <= next_rlatch;
    end
  end
endmodule

// ==== tec16_map.vh ====
// Register map, field positions and codes for the 16-bit timer/event counter.
`ifndef TEC16_MAP_VH
`define TEC16_MAP_VH
`define ADDR_CC_A 16'hff12
`define ADDR_CC_A_HI 16'hff13
`define ADDR_CC_B 16'hff14
`define ADDR_CC_B_HI 16'hff15
`define ADDR_MODE_CONTROL 16'hffba
`define ADDR_CC_CONTROL 16'hffbc
`define ADDR_OUTPUT_CONTROL 16'hffbd
`define ADDR_PRESCALE 16'hffbb
`define ADDR_COUNT 16'hff10
`define ADDR_COUNT_HI 16'hff11
`define RST16 16'h0000
`define RST8 8'h00
`define COUNT_MAX 16'hffff
`define COUNT_ONE 16'h0001
`define RUN_STOP 2'b00
`define RUN_FREE 2'b01
`define RUN_CLR_EDGE 2'b10
`define RUN_CLR_MATCH 2'b11
`define EDGE_FALL 2'b00
`define EDGE_RISE 2'b01
`define EDGE_BOTH 2'b11
`define MC_OVF 0
`define MC_INV 1
`define MC_RUN_LO 2
`define MC_RUN_HI 3
`define CC_A_CAPT 0
`define CC_A_SRC 1
`define CC_B_CAPT 2
`define OC_ENABLE 0
`define OC_INV_A 1
`define OC_LVR 2
`define OC_LVS 3
`define OC_INV_B 4
`define OC_ONESHOT 5
`define OC_TRIG 6
`define PS_EA_LO 4
`define PS_EA_HI 5
`define PS_EB_LO 6
`define PS_EB_HI 7
`endif

// ==== edge_sync.v ====
// Input synchroniser and valid-edge detector for one external pin.
`timescale 1ns/10ps
`include "tec16_map.vh"
module edge_sync (
  // Clock and reset
  input wire i_core_clk,
  input wire i_arst_n,
  // Pin and edge selection
  input wire i_pin,
  input wire [1:0] i_sel,
  // Detected edges, one-cycle pulses
  output reg o_valid,
  output reg o_reverse
);
  reg meta;
  reg sync;
  reg prev;
  wire rise;
  wire fall;

  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

  // The first stage feeds only the second stage.
  always @(posedge i_core_clk or negedge i_arst_n) begin // RULE25
    if (!i_arst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      o_valid <= 1'b0;
      o_reverse <= 1'b0;
    end else begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
      case (i_sel) // RULE12
        `EDGE_FALL: begin
          o_valid <= fall;
          o_reverse <= rise;
        end
        `EDGE_RISE: begin
          o_valid <= rise;
          o_reverse <= fall;
        end
        `EDGE_BOTH: begin
          o_valid <= rise | fall;
          o_reverse <= 1'b0; // RULE13
        end
        default: begin
          o_valid <= 1'b0;
          o_reverse <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== tec16_chk.sv ====
// Port-level assertion checker for the 16-bit timer/event counter.
`timescale 1ns/10ps
module tec16_chk (
  // Clock and reset
  input wire i_core_clk,
  input wire i_arst_n,
  // Bus, count enable, pins and requests
  input wire i_count_en,
  input wire [15:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire i_edge_in_a,
  input wire i_edge_in_b,
  input wire o_timer_out,
  input wire o_match_irq_a,
  input wire o_match_irq_b
);
  // Shadow control registers, so antecedents know the mode in force.
  logic [7:0] mode, cca, psel;
  logic [3:0] quiet;
  logic pa, pb;
  wire run = mode[3:2] != 2'b00;
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode <= 8'h00;
      cca <= 8'h00;
      psel <= 8'h00;
      quiet <= 4'h0;
      pa <= 1'b0;
      pb <= 1'b0;
    end else begin
      pa <= i_edge_in_a;
      pb <= i_edge_in_b;
      if (i_wr && i_addr == 16'hffba) mode <= i_wdata;
      if (i_wr && i_addr == 16'hffbc) cca <= i_wdata;
      if (i_wr && i_addr == 16'hffbb) psel <= i_wdata;
      if (run || pa != i_edge_in_a || pb != i_edge_in_b) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data seen without a read");
  property p_stop_read;
    i_rd && !run && i_addr[15:1] == 15'h7f88 |=> o_rdata == 8'h00;
  endproperty
  a_stop_read: assert property (p_stop_read)
    else $error("count not zero while stopped");
  property p_stop_quiet;
    !run && quiet == 4'hf |-> !o_match_irq_a && !o_match_irq_b;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("request while stopped");
  property p_irq_b_pulse; o_match_irq_b |=> !o_match_irq_b; endproperty
  a_irq_b_pulse: assert property (p_irq_b_pulse)
    else $error("request b longer than one cycle");
  property p_capt_a;
    run && cca[1:0] == 2'b01 && psel[7:6] == 2'b01 && $rose(i_edge_in_b)
      |-> ##[2:6] o_match_irq_a;
  endproperty
  a_capt_a: assert property (p_capt_a)
    else $error("no request a after capture");
  property p_capt_b;
    run && cca[2] && psel[5:4] == 2'b01 && $rose(i_edge_in_a)
      |-> ##[2:6] o_match_irq_b;
  endproperty
  a_capt_b: assert property (p_capt_b)
    else $error("no request b after capture");
  property p_fall_edge;
    run && cca[2] && psel[5] == psel[4] && $fell(i_edge_in_a)
      |-> ##[2:6] o_match_irq_b;
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("falling edge not taken");
  property p_no_rise;
    run && cca[2] && psel[5:4] == 2'b00 && $rose(i_edge_in_a)
      |-> ##1 !o_match_irq_b [*6];
  endproperty
  a_no_rise: assert property (p_no_rise)
    else $error("rising edge taken with fall select");
  property p_rev_silent;
    run && cca[1:0] == 2'b11 && psel[5:4] == 2'b01 && $fell(i_edge_in_a)
      && $stable(i_edge_in_b) |-> ##1 !o_match_irq_a [*6];
  endproperty
  a_rev_silent: assert property (p_rev_silent)
    else $error("request a on reverse capture");
  c_irq_a: cover property (run && o_match_irq_a);
  c_capt_b: cover property (cca[2] && o_match_irq_b);
  c_run_rd: cover property (run && i_rd);
endmodule

// ==== tec16_pins.sv ====
// Pulse sources on the two edge pins and a tally of interrupt requests.
`timescale 1ns/10ps
module tec16_pins (
  // Clock and reset
  input wire i_core_clk,
  input wire i_arst_n,
  // Toggle requests and interrupt requests
  input wire [1:0] i_toggle,
  input wire i_irq_a,
  input wire i_irq_b,
  // Pin levels and request counts
  output logic o_pin_a,
  output logic o_pin_b,
  output logic [7:0] o_cnt_a,
  output logic [7:0] o_cnt_b
);
  // A level is held until the next request, which the bench spaces apart.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_a <= 1'b0;
      o_pin_b <= 1'b0;
      o_cnt_a <= 8'h00;
      o_cnt_b <= 8'h00;
    end else begin
      if (i_toggle[0]) o_pin_a <= ~o_pin_a;
      if (i_toggle[1]) o_pin_b <= ~o_pin_b;
      if (i_irq_a) o_cnt_a <= o_cnt_a + 8'h01;
      if (i_irq_b) o_cnt_b <= o_cnt_b + 8'h01;
    end
  end
endmodule

// ==== timer_event_counter_16bit_tb_top.sv ====
// Self-checking bench for the 16-bit timer/event counter.
`timescale 1ns/10ps
`define CHK(n, e, a) begin if ((a) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, a); \
  miscompares++; end n_checks++; end
module timer_event_counter_16bit_tb_top;
  logic i_core_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_count_en = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic [1:0] tgl = 2'b00;
  wire [7:0] o_rdata, cnt_a, cnt_b;
  wire o_timer_out, o_match_irq_a, o_match_irq_b, pin_a, pin_b;
  logic [7:0] e, base_a = 8'h00, base_b = 8'h00;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  logic [15:0] k, r, rv;
  logic [7:0] ps_t[3] = '{8'h00, 8'h10, 8'h30};
  logic [15:0] c_t[3] = '{16'd2, 16'd5, 16'd2};
  logic [7:0] b_t[3] = '{8'd1, 8'd1, 8'd2};
  always #4 i_core_clk = ~i_core_clk;
  timer_event_counter_16bit i_dut (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_count_en(i_count_en), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_edge_in_a(pin_a), .i_edge_in_b(pin_b), .o_timer_out(o_timer_out),
    .o_match_irq_a(o_match_irq_a), .o_match_irq_b(o_match_irq_b));
  tec16_pins i_pins (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_toggle(tgl), .i_irq_a(o_match_irq_a), .i_irq_b(o_match_irq_b),
    .o_pin_a(pin_a), .o_pin_b(pin_b), .o_cnt_a(cnt_a), .o_cnt_b(cnt_b));
  // Read results are compared one cycle after the read is taken.
  always @(posedge i_core_clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, o_rdata)
    end
    rd_d <= i_rd;
  end
  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(d);
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  endtask
  // Both halves in order, low byte first, as 16-bit access demands.
  task automatic wr16(input logic [15:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 16'h0001, v[15:8]);
  endtask
  task automatic rd16(input logic [15:0] a, input logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 16'h0001, v[15:8]);
  endtask
  task automatic pulse(input int n);
    @(posedge i_core_clk);
    i_count_en <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    i_count_en <= 1'b0;
  endtask
  task automatic tog(input int i);
    @(posedge i_core_clk);
    tgl[i] <= 1'b1;
    @(posedge i_core_clk);
    tgl[i] <= 1'b0;
    repeat (8) @(posedge i_core_clk);
  endtask
  task automatic irqs(input logic [7:0] ea, input logic [7:0] eb);
    repeat (3) @(posedge i_core_clk);
    `CHK("irq_a", base_a + ea, cnt_a)
    `CHK("irq_b", base_b + eb, cnt_b)
    base_a = cnt_a;
    base_b = cnt_b;
  endtask
  initial begin
    repeat (99000) @(posedge i_core_clk);
    miscompares++;
    stop_test;
  end
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(65240));
    k = 16'($urandom_range(200, 1));
    r = 16'($urandom_range(50, 1));
    rv = 16'h8000 | 16'($urandom);
    repeat (5) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    rd16(16'hff12, 16'h0000);
    rd16(16'hff14, 16'h0000);
    rd(16'hffba, 8'h00);
    rd(16'hff00, 8'h00);
    wr16(16'hff14, rv);
    rd16(16'hff14, rv);
    wr(16'hffbd, 8'h20);
    wr(16'hffba, 8'h04);
    pulse(k);
    rd16(16'hff10, k);
    wr(16'hffbd, 8'h60);
    pulse(2);
    rd16(16'hff10, 16'h0002);
    rd16(16'hff14, rv);
    pulse(65536);
    irqs(8'd3, 8'd1);
    rd(16'hffba, 8'h05);
    wr(16'hffba, 8'h00);
    rd(16'hffba, 8'h00);
    rd16(16'hff10, 16'h0000);
    wr16(16'hff12, r);
    wr16(16'hff14, 16'h0000);
    wr(16'hffba, 8'h0c);
    pulse(3 * (r + 1));
    irqs(8'd3, 8'd3);
    rd16(16'hff10, 16'h0000);
    wr(16'hffba, 8'h00);
    wr16(16'hff12, 16'hffff);
    wr(16'hffbc, 8'h04);
    for (int i = 0; i < 3; i++) begin
      wr(16'hffbb, ps_t[i]);
      wr(16'hffba, 8'h08);
      pulse(5);
      tog(0);
      pulse(3);
      tog(0);
      pulse(2);
      rd16(16'hff10, c_t[i]);
      irqs(8'd0, b_t[i]);
      wr(16'hffba, 8'h00);
    end
    wr16(16'hff14, 16'h0000);
    wr(16'hffbc, 8'h01);
    wr(16'hffbb, 8'h40);
    wr(16'hffba, 8'h04);
    pulse(k);
    tog(1);
    rd16(16'hff12, k);
    irqs(8'd1, 8'd1);
    tog(1);
    wr(16'hffba, 8'h00);
    wr(16'hffbd, 8'h19);
    wr(16'hffbc, 8'h03);
    wr(16'hffbb, 8'h50);
    wr(16'hffba, 8'h04);
    @(posedge i_core_clk);
    `CHK("timer_out", 1'b1, o_timer_out)
    pulse(k);
    tog(0);
    `CHK("timer_out", 1'b0, o_timer_out)
    pulse(3);
    tog(0);
    rd16(16'hff12, k + 16'h0003);
    irqs(8'd0, 8'd1);
    tog(1);
    irqs(8'd1, 8'd0);
    rd16(16'hff12, k + 16'h0003);
    repeat (3) @(posedge i_core_clk);
    stop_test;
  end
endmodule
bind timer_event_counter_16bit tec16_chk i_chk (.i_core_clk(i_core_clk),
  .i_arst_n(i_arst_n), .i_count_en(i_count_en), .i_addr(i_addr),
  .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .i_edge_in_a(i_edge_in_a), .i_edge_in_b(i_edge_in_b),
  .o_timer_out(o_timer_out), .o_match_irq_a(o_match_irq_a),
  .o_match_irq_b(o_match_irq_b));
